// File: design/lecs_lane_tally.sv
/*
 * lecs_lane_tally: one lane's 12-bit error tally with event selection.
 * assumes: event inputs already synchronous to I_CORE_CLK, one pulse per event.
 */
`timescale 1ns/1ps
module lecs_lane_tally
    import lecs_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // control
    input  wire logic        i_clear,
    input  wire logic [2:0]  i_src_sel,
    // events
    input  wire logic        i_data_err,
    input  wire logic        i_buf_err,
    input  wire logic        i_buf_ovf,
    input  wire logic        i_buf_unf,
    input  wire logic        i_deskew_err,
    // tally
    output logic      [11:0] o_tally
);
    logic event_sel;
    logic [11:0] tally_q;

    // ==========================================================
    // source select
    always_comb begin
        case (i_src_sel)
            LECS_SRC_DATA_ERR: event_sel = i_data_err;
            LECS_SRC_BUF_ERR:  event_sel = i_buf_err;
            LECS_SRC_BUF_OVF:  event_sel = i_buf_ovf;
            LECS_SRC_BUF_UNF:  event_sel = i_buf_unf;
            LECS_SRC_DESKEW:   event_sel = i_deskew_err;
            default:           event_sel = 1'b0;           // reserved codes count nothing
        endcase
    end

    // ==========================================================
    // tally; saturates so a long soak never wraps to a small number
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tally_q <= LECS_TALLY_RESET;
        end else if (i_clear) begin
            tally_q <= LECS_TALLY_RESET;
        end else if (event_sel && tally_q != LECS_TALLY_MAX) begin
            tally_q <= tally_q + 12'h001;
        end
    end

    assign o_tally = tally_q;
endmodule : lecs_lane_tally

// File: design/lecs_pkg.sv
/*
 * lecs_pkg: register offsets, field positions, reset values and count-source
 * codes for the lane error tally status registers.
 * assumes: 8-bit register port driven by the device's configuration bridge.
 */
package lecs_pkg;
    // ==========================================================
    // widths
    localparam int unsigned LECS_LANES     = 4;
    localparam int unsigned LECS_TALLY_W   = 12;
    localparam int unsigned LECS_ADDR_W    = 8;
    localparam int unsigned LECS_DATA_W    = 8;
    // ==========================================================
    // register offsets
    localparam logic [7:0] LECS_OFS_L0_LOW   = 8'h18;
    localparam logic [7:0] LECS_OFS_L0_HIGH  = 8'h19;
    localparam logic [7:0] LECS_OFS_L1_LOW   = 8'h1A;
    localparam logic [7:0] LECS_OFS_L1_HIGH  = 8'h1B;
    localparam logic [7:0] LECS_OFS_L2_LOW   = 8'h1C;
    localparam logic [7:0] LECS_OFS_L2_HIGH  = 8'h1D;
    localparam logic [7:0] LECS_OFS_L3_LOW   = 8'h1E;
    localparam logic [7:0] LECS_OFS_L3_HIGH  = 8'h1F;
    localparam logic [7:0] LECS_OFS_POWER    = 8'h20;
    // ==========================================================
    // fields of the power state status register, reset values and tally limits
    localparam int unsigned LECS_PWR_DOWN_BIT  = 7;
    localparam int unsigned LECS_PWR_RW_LSB    = 4;
    localparam int unsigned LECS_PWR_RW_W      = 2;
    localparam logic [7:0]  LECS_RESET_VALUE   = 8'h00;
    localparam logic [11:0] LECS_TALLY_RESET   = 12'h000;
    localparam logic [11:0] LECS_TALLY_MAX     = 12'hFFF;
    // ==========================================================
    // count source select codes
    typedef enum logic [2:0] {
        LECS_SRC_DATA_ERR   = 3'h0,
        LECS_SRC_BUF_ERR    = 3'h1,
        LECS_SRC_BUF_OVF    = 3'h2,
        LECS_SRC_BUF_UNF    = 3'h3,
        LECS_SRC_DESKEW     = 3'h4
    } lecs_src_t;
endpackage : lecs_pkg

// File: design/lecs_regs.sv
/*
 * lecs_regs: lane error tally and power state status registers.
 * assumes: 8-bit register port (address, write strobe, write data, read data)
 * from the device's configuration bridge; events synchronous to I_CORE_CLK;
 * power-down and clear/select come from neighbouring device logic.
 */
`timescale 1ns/1ps
// What this block does
// - Register 0x19 low nibble shows lane 0 tally bits 11:8, read-only, reset zero.
// - Lane 1 tally: low byte at 0x1A, high nibble at 0x1B, read-only.
// - Lane 2 tally: low byte at 0x1C, high nibble at 0x1D, read-only.
// - Lane 3 tally: low byte at 0x1E, high nibble at 0x1F, read-only.
// - Writes never change tallies; upper nibbles of high registers read zero.
// - Register 0x20 bit 7 reads one while powered down, else zero.
// - Register 0x20 bits 5:4 are read/write, reset zero; others read zero.
// - Register 0x18 holds lane 0 tally bits 7:0.
// - Rising edge of the clear control zeroes all tallies.
// - Three-bit select picks counted event; codes 5 to 7 count nothing.
module lecs_regs
    import lecs_pkg::*;
(
    // clock and reset
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_RST,
    // register port
    input  wire logic [7:0]  I_REG_ADDR,
    input  wire logic        I_REG_WR,
    input  wire logic [7:0]  I_REG_WDATA,
    output logic      [7:0]  O_REG_RDATA,
    // control from neighbouring registers
    input  wire logic        I_ERROR_TALLY_CLEAR,
    input  wire logic [2:0]  I_COUNT_SOURCE_SELECT,
    // per-lane events
    input  wire logic [3:0]  I_DATA_ERR,
    input  wire logic [3:0]  I_BUF_ERR,
    input  wire logic [3:0]  I_BUF_OVF,
    input  wire logic [3:0]  I_BUF_UNF,
    input  wire logic [3:0]  I_DESKEW_ERR,
    // power state
    input  wire logic        I_POWERDOWN,
    output logic             O_POWERDOWN_INDICATOR,
    output logic      [1:0]  O_POWER_CTRL
);
    logic        clear_prev_q;
    logic        clear_pulse;
    logic [11:0] tally [LECS_LANES];
    logic [1:0]  pwr_ctrl_q;
    logic        pwr_down_q;
    logic [7:0]  rdata_q;
    logic [7:0]  rdata_d;

    // ==========================================================
    // clear edge detect
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            clear_prev_q <= 1'b0;
        end else begin
            clear_prev_q <= I_ERROR_TALLY_CLEAR;
        end
    end
    assign clear_pulse = I_ERROR_TALLY_CLEAR & ~clear_prev_q;

    // ==========================================================
    // per-lane tallies
    genvar g;
    generate
        for (g = 0; g < LECS_LANES; g++) begin : g_lane
            lecs_lane_tally u_tally (
                .i_clk        (I_CORE_CLK),
                .i_rst        (I_RST),
                .i_clear      (clear_pulse),
                .i_src_sel    (I_COUNT_SOURCE_SELECT),
                .i_data_err   (I_DATA_ERR[g]),
                .i_buf_err    (I_BUF_ERR[g]),
                .i_buf_ovf    (I_BUF_OVF[g]),
                .i_buf_unf    (I_BUF_UNF[g]),
                .i_deskew_err (I_DESKEW_ERR[g]),
                .o_tally      (tally[g])
            );
        end
    endgenerate

    // ==========================================================
    // power state register
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            pwr_ctrl_q <= LECS_RESET_VALUE[LECS_PWR_RW_LSB +: LECS_PWR_RW_W];
        end else if (I_REG_WR && I_REG_ADDR == LECS_OFS_POWER) begin
            pwr_ctrl_q <= I_REG_WDATA[LECS_PWR_RW_LSB +: LECS_PWR_RW_W];
        end
    end

    // power-down level is a plain status, registered once on the core clock
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            pwr_down_q <= 1'b0;
        end else begin
            pwr_down_q <= I_POWERDOWN;
        end
    end

    // ==========================================================
    // read mux; tally registers have no write path at all
    always_comb begin
        rdata_d = 8'h00;
        case (I_REG_ADDR)
            LECS_OFS_L0_LOW:  rdata_d = tally[0][7:0];
            LECS_OFS_L0_HIGH: rdata_d = {4'h0, tally[0][11:8]};
            LECS_OFS_L1_LOW:  rdata_d = tally[1][7:0];
            LECS_OFS_L1_HIGH: rdata_d = {4'h0, tally[1][11:8]};
            LECS_OFS_L2_LOW:  rdata_d = tally[2][7:0];
            LECS_OFS_L2_HIGH: rdata_d = {4'h0, tally[2][11:8]};
            LECS_OFS_L3_LOW:  rdata_d = tally[3][7:0];
            LECS_OFS_L3_HIGH: rdata_d = {4'h0, tally[3][11:8]};
            // bit 6 belongs to a neighbouring status and reads zero here
            LECS_OFS_POWER:   rdata_d = {pwr_down_q, 1'h0, pwr_ctrl_q, 4'h0};
            default:          rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            rdata_q <= LECS_RESET_VALUE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign O_REG_RDATA           = rdata_q;
    assign O_POWERDOWN_INDICATOR = pwr_down_q;
    assign O_POWER_CTRL          = pwr_ctrl_q;
endmodule : lecs_regs

// File: dv/lecs_regs_monitor.sv
/* lecs_regs_monitor: concurrent checks on the tally and power status register ports.
   assumes: bound to lecs_regs; one clock, synchronous active-high reset. */
`timescale 1ns/1ps
module lecs_regs_monitor (
    input wire logic       I_CORE_CLK, I_RST, I_REG_WR, I_ERROR_TALLY_CLEAR, I_POWERDOWN,
    input wire logic       O_POWERDOWN_INDICATOR,
    input wire logic [7:0] I_REG_ADDR, I_REG_WDATA, O_REG_RDATA,
    input wire logic [1:0] O_POWER_CTRL
);
    // ==========================================================
    // checks
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RST);
    logic pwr_wr;
    assign pwr_wr = I_REG_WR && I_REG_ADDR == 8'h20;
    chk_reset_zero: assert property ($past(I_RST) |-> O_REG_RDATA == 8'h00 && O_POWER_CTRL == 2'h0)
        else $error("outputs not zero after reset");
    chk_ind_follow: assert property (!$past(I_RST) |-> O_POWERDOWN_INDICATOR == $past(I_POWERDOWN))
        else $error("power-down indicator lags wrongly");
    chk_ctrl_write: assert property (pwr_wr |=> O_POWER_CTRL == $past(I_REG_WDATA[5:4]))
        else $error("control bits not written");
    chk_ctrl_hold: assert property (!pwr_wr |=> $stable(O_POWER_CTRL))
        else $error("control bits changed without a write");
    chk_pwr_read: assert property (I_REG_ADDR == 8'h20 |=> O_REG_RDATA[7] == $past(O_POWERDOWN_INDICATOR)
        && O_REG_RDATA[6] == 1'b0 && O_REG_RDATA[3:0] == 4'h0) else $error("power status read wrong");
    chk_high_nibble: assert property (I_REG_ADDR inside {8'h19, 8'h1B, 8'h1D, 8'h1F}
        |=> O_REG_RDATA[7:4] == 4'h0) else $error("reserved nibble not zero");
    chk_unmapped_zero: assert property (!(I_REG_ADDR inside {[8'h18:8'h20]}) |=> O_REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    chk_clear_zero: assert property ($rose(I_ERROR_TALLY_CLEAR) ##1 I_REG_ADDR == 8'h1E
        |=> O_REG_RDATA == 8'h00) else $error("tally not cleared");
endmodule : lecs_regs_monitor
bind lecs_regs lecs_regs_monitor mon_u (.I_CORE_CLK, .I_RST, .I_REG_WR, .I_ERROR_TALLY_CLEAR,
    .I_POWERDOWN, .O_POWERDOWN_INDICATOR, .I_REG_ADDR, .I_REG_WDATA, .O_REG_RDATA, .O_POWER_CTRL);

// File: dv/tb.sv
/* tb: directed register-read bench for the lane error tally status block.
   assumes: read data registered, one cycle behind the address. */
`timescale 1ns/1ps
module tb;
    import lecs_pkg::*;
    logic            clk = 1'b0, rst = 1'b1, wr = 1'b0, clr = 1'b0, pd = 1'b0, ind;
    logic [7:0]      addr = 8'h00, wdata = 8'h00, rdata;
    logic [2:0]      sel = 3'h0;
    logic [4:0][3:0] ev = '0;
    logic [1:0]      ctrl;
    int              n_fail = 0, n_compared = 0;
    always #5 clk = ~clk;
    lecs_regs dut_u (.I_CORE_CLK(clk), .I_RST(rst), .I_REG_ADDR(addr), .I_REG_WR(wr),
        .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .I_ERROR_TALLY_CLEAR(clr),
        .I_COUNT_SOURCE_SELECT(sel), .I_DATA_ERR(ev[0]), .I_BUF_ERR(ev[1]), .I_BUF_OVF(ev[2]),
        .I_BUF_UNF(ev[3]), .I_DESKEW_ERR(ev[4]), .I_POWERDOWN(pd),
        .O_POWERDOWN_INDICATOR(ind), .O_POWER_CTRL(ctrl));
    // ==========================================================
    // access tasks: all start and end 1 ns after a rising edge
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        tick(2);
        chk(rdata, exp);
    endtask : rd
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        // strobe stays low across one edge so back-to-back writes never re-raise it at once
        tick(1);
    endtask : wr8
    task automatic clear();
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
        tick(1);
    endtask : clear
    task automatic print_verdict();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict
    // ==========================================================
    // scenarios
    initial begin
        tick(12);
        rst = 1'b0;
        for (int a = 8'h18; a <= 8'h20; a++) rd(8'(a), 8'h00);
        // one pulse of every source per code: only the selected source may count
        for (int c = 0; c < 8; c++) begin
            clear();
            sel = 3'(c);
            for (int s = 0; s < 5; s++) begin
                ev[s][c % 4] = 1'b1;
                tick(1);
                ev[s] = 4'h0;
            end
            for (int a = 8'h18; a < 8'h20; a++) wr8(8'(a), 8'hFF);
            for (int l = 0; l < 4; l++) begin
                rd(8'(8'h18 + 2 * l), (l == c % 4 && c < 5) ? 8'h01 : 8'h00);
                rd(8'(8'h19 + 2 * l), 8'h00);
            end
        end
        clear();
        sel = LECS_SRC_DATA_ERR;
        ev[0] = 4'hC;
        tick(300);
        ev[0] = 4'h8;
        tick(3800);
        ev[0] = 4'h0;
        rd(8'h1C, 8'h2C);
        rd(8'h1D, 8'h01);
        rd(8'h1F, 8'h0F);
        rd(8'h1E, 8'hFF);
        clr = 1'b1;
        ev[0] = 4'hF;
        tick(1);
        clr = 1'b0;
        ev[0] = 4'h0;
        rd(8'h1E, 8'h00);
        pd = 1'b1;
        wr8(8'h20, 8'hFF);
        chk({6'h00, ctrl}, 8'h03);
        chk({7'h00, ind}, 8'h01);
        rd(8'h20, 8'hB0);
        pd = 1'b0;
        wr8(8'h20, 8'h0F);
        rd(8'h20, 8'h00);
        chk({7'h00, ind}, 8'h00);
        wr8(8'h21, 8'hFF);
        rd(8'h21, 8'h00);
        print_verdict();
    end
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
endmodule : tb
